// ---- core/sbt_defines.svh ----
// Purpose : constants of the sram boundary-scan test access port
// Assumes : included by its bare name from the tap design file
// Notes   : every offset, field position, reset value and code lives here
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

// register lengths
`define SBT_IR_W          3
`define SBT_BSR_LEN       89
`define SBT_BSR_MSB       88
`define SBT_OBT_CELL      88
`define SBT_ID_W          32

// instruction codes (only extest is fixed; the rest are plain defaults)
`define SBT_OP_EXTEST     3'h0
`define SBT_OP_IDCODE     3'h1
`define SBT_OP_SAMPLEZ    3'h2
`define SBT_OP_SAMPLE     3'h4
`define SBT_OP_BYPASS     3'h7

// capture-ir pattern, low two bits fixed at binary 01
`define SBT_IR_CAPTURE    3'h1

// boundary register reset: only the output-bus tri-state cell is set
`define SBT_BSR_RESET     89'h100_0000_0000_0000_0000_0000

// identification fields; part and maker values are arbitrary
`define SBT_ID_REV        3'h0
`define SBT_ID_PART       17'h0_5A5A
`define SBT_ID_MFR        11'h125
`define SBT_ID_PRESENT    1'h1

// test-logic-reset entry needs this many tms-high rising edges
`define SBT_TLR_EDGES     5

`endif

// ---- core/sbt_pkg.sv ----
// Purpose : types shared by the boundary-scan tap
// Assumes : nothing beyond the defines header
// Notes   : state codes are one-hot, sixteen states
`default_nettype none

package sbt_pkg;

    typedef enum logic [15:0] {
        ST_RESET    = 16'h0001,
        ST_IDLE     = 16'h0002,
        ST_SEL_DR   = 16'h0004,
        ST_CAP_DR   = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR   = 16'h0100,
        ST_SEL_IR   = 16'h0200,
        ST_CAP_IR   = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR   = 16'h8000
    } sbt_state_t;

    typedef logic [2:0] sbt_op_t;

endpackage : sbt_pkg

`default_nettype wire

// ---- core/sbt_tap.sv ----
// Purpose : boundary-scan test access port of a pipelined sram
// Assumes : tck is the link clock; clk_sys clocks the memory-side pins
// Notes   : ring values cross per bit; updates cross by toggle handshake
//
// Functional notes
// RULE_01 - sample test inputs on tck rise, change test outputs on tck fall
// RULE_02 - mode select sampled on tck rise; pad pull-up makes open reads high
// RULE_03 - serial in enters msb, serial out leaves lsb of selected register
// RULE_04 - tdo driven only in shift states, else high impedance, fall-updated
// RULE_05 - five tms-high rising edges reach test-logic-reset, memory undisturbed
// RULE_06 - power-up reset puts tdo in high impedance
// RULE_07 - exactly one register between tdi and tdo, chosen by instruction
// RULE_08 - three-bit instruction register holds idcode after reset
// RULE_09 - capture-ir loads binary 01 into the two low bits
// RULE_10 - bypass is one flop cleared when bypass executes
// RULE_11 - bypass instruction in shift-dr puts bypass flop in path
// RULE_12 - boundary register captures ring in capture-dr, shifts in shift-dr
// RULE_13 - idcode captures a fixed 32-bit code and shifts it out
// RULE_14 - controller must never load the three reserved codes; ir loads them at update-ir and decodes them as bypass
// RULE_15 - instructions shift in shift-ir, take effect only at update-ir
// RULE_16 - extest drives pins from preloaded cells, selects boundary register
// RULE_17 - sample-z selects boundary register, forces memory outputs off
// RULE_18 - sample/preload captures pin snapshot in capture-dr
// RULE_19 - cells shift out capture while shifting preload in; update latches
// RULE_20 - cell 89 latched at update-dr gates output bus under extest
// RULE_21 - tri-state cell preset high at power-up and in test-logic-reset
// RULE_22 - extest is coded binary 000
// RULE_23 - boundary register is 89 cells long
// RULE_24 - id holds revision 31:29, maker 11:1, constant one in bit 0
// RULE_25 - standard sixteen-state controller driven by sampled tms
// RULE_26 - idcode connects the id register in shift-dr
`include "sbt_defines.svh"
`default_nettype none

module sbt_tap #(
    parameter logic [16:0] ID_PART = `SBT_ID_PART,  // arbitrary value
    parameter logic [10:0] ID_MFR  = `SBT_ID_MFR    // arbitrary value
) (
    // system side
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    ce,
    // test link
    input  wire logic                    tck,
    input  wire logic                    tms,
    input  wire logic                    tdi,
    output logic                         tdo,
    output logic                         tdo_oe,
    // memory pin ring
    input  wire logic [`SBT_BSR_MSB:0]   ring_in,
    output logic      [`SBT_BSR_MSB:0]   ring_out,
    output logic                         ring_extest,
    output logic                         bus_drive_en
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // instructions that put the boundary register in the path
    function automatic logic sbt_is_bsr(input sbt_pkg::sbt_op_t op);
        sbt_is_bsr = (op == `SBT_OP_EXTEST) || (op == `SBT_OP_SAMPLE)
                  || (op == `SBT_OP_SAMPLEZ);
    endfunction : sbt_is_bsr

    ////////////////////////////////////////////////////////////////////////////
    // tck-domain state

    sbt_pkg::sbt_state_t      state;
    sbt_pkg::sbt_state_t      next_state;
    sbt_pkg::sbt_op_t         ir;
    logic [`SBT_IR_W-1:0]     ir_shift;
    logic                     bypass;
    logic [`SBT_ID_W-1:0]     id_shift;
    logic [`SBT_BSR_MSB:0]    bsr_shift;                        // RULE_23
    logic [`SBT_BSR_MSB:0]    bsr_update;
    logic                     upd_toggle;
    logic                     rst_meta;
    logic                     rst_s2;
    logic                     rst_s3;
    logic                     rst_tck;
    logic [`SBT_BSR_MSB:0]    ring_meta;
    logic [`SBT_BSR_MSB:0]    ring_s2;
    logic [`SBT_BSR_MSB:0]    ring_s3;
    logic [`SBT_BSR_MSB:0]    ring_q;

    ////////////////////////////////////////////////////////////////////////////
    // system-domain state

    logic                     tog_meta;
    logic                     tog_s2;
    logic                     tog_s3;
    logic                     tog_seen;
    logic                     sys_samplez;

    ////////////////////////////////////////////////////////////////////////////
    // decode wires

    wire logic [`SBT_ID_W-1:0] id_value = {`SBT_ID_REV, ID_PART, ID_MFR,
                                           `SBT_ID_PRESENT};    // RULE_24
    wire logic sel_bsr    = sbt_is_bsr(ir);                     // RULE_16
    wire logic sel_id     = (ir == `SBT_OP_IDCODE);             // RULE_26
    // reserved codes fall to bypass so the chain never breaks
    wire logic sel_bypass = !sel_bsr && !sel_id;                // RULE_14
    wire logic in_shift   = (state == sbt_pkg::ST_SHIFT_DR)
                         || (state == sbt_pkg::ST_SHIFT_IR);
    wire logic dr_lsb     = sel_bsr ? bsr_shift[0] :
                            sel_id  ? id_shift[0]  : bypass;    // RULE_07
    wire logic next_tdo   = (state == sbt_pkg::ST_SHIFT_IR) ? ir_shift[0]
                                                            : dr_lsb;  // RULE_03
    wire logic [`SBT_BSR_MSB:0] ring_agree = ~(ring_s2 ^ ring_s3);
    wire logic tog_new    = (tog_s2 == tog_s3) && (tog_s3 != tog_seen);
    wire logic upd_event  = (state == sbt_pkg::ST_UPD_IR)
                         || ((state == sbt_pkg::ST_UPD_DR) && sel_bsr)
                         || ((state != sbt_pkg::ST_RESET)
                             && (next_state == sbt_pkg::ST_RESET));

    ////////////////////////////////////////////////////////////////////////////
    // reset into the tck domain; tck must run for the power-up reset to land

    always_ff @(posedge tck) begin
        rst_meta <= rst;
        rst_s2   <= rst_meta;
        rst_s3   <= rst_s2;
        if (rst_s2 == rst_s3) begin
            rst_tck <= rst_s3;                                  // RULE_06
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ring pins into the tck domain; capture may still catch a moving pin

    always_ff @(posedge tck) begin
        ring_meta <= ring_in;
        ring_s2   <= ring_meta;
        ring_s3   <= ring_s2;
        ring_q    <= (ring_agree & ring_s3) | (~ring_agree & ring_q);
    end

    ////////////////////////////////////////////////////////////////////////////
    // controller next state, tms read as sampled at the rising edge

    always_comb begin
        next_state = state;
        case (state)                                            // RULE_25
            sbt_pkg::ST_RESET:    next_state = tms ? sbt_pkg::ST_RESET
                                                   : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_IDLE:     next_state = tms ? sbt_pkg::ST_SEL_DR
                                                   : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_DR:   next_state = tms ? sbt_pkg::ST_SEL_IR
                                                   : sbt_pkg::ST_CAP_DR;
            sbt_pkg::ST_CAP_DR:   next_state = tms ? sbt_pkg::ST_EXIT1_DR
                                                   : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_SHIFT_DR: next_state = tms ? sbt_pkg::ST_EXIT1_DR
                                                   : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_EXIT1_DR: next_state = tms ? sbt_pkg::ST_UPD_DR
                                                   : sbt_pkg::ST_PAUSE_DR;
            sbt_pkg::ST_PAUSE_DR: next_state = tms ? sbt_pkg::ST_EXIT2_DR
                                                   : sbt_pkg::ST_PAUSE_DR;
            sbt_pkg::ST_EXIT2_DR: next_state = tms ? sbt_pkg::ST_UPD_DR
                                                   : sbt_pkg::ST_SHIFT_DR;
            sbt_pkg::ST_UPD_DR:   next_state = tms ? sbt_pkg::ST_SEL_DR
                                                   : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_IR:   next_state = tms ? sbt_pkg::ST_RESET  // RULE_05
                                                   : sbt_pkg::ST_CAP_IR;
            sbt_pkg::ST_CAP_IR:   next_state = tms ? sbt_pkg::ST_EXIT1_IR
                                                   : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_SHIFT_IR: next_state = tms ? sbt_pkg::ST_EXIT1_IR
                                                   : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_EXIT1_IR: next_state = tms ? sbt_pkg::ST_UPD_IR
                                                   : sbt_pkg::ST_PAUSE_IR;
            sbt_pkg::ST_PAUSE_IR: next_state = tms ? sbt_pkg::ST_EXIT2_IR
                                                   : sbt_pkg::ST_PAUSE_IR;
            sbt_pkg::ST_EXIT2_IR: next_state = tms ? sbt_pkg::ST_UPD_IR
                                                   : sbt_pkg::ST_SHIFT_IR;
            sbt_pkg::ST_UPD_IR:   next_state = tms ? sbt_pkg::ST_SEL_DR
                                                   : sbt_pkg::ST_IDLE;
            default:              next_state = sbt_pkg::ST_RESET;
        endcase
    end

    // state register; open tms pad pulls high, so an idle link parks in reset
    always_ff @(posedge tck) begin
        if (rst_tck) begin
            state <= sbt_pkg::ST_RESET;                         // RULE_06
        end else begin
            state <= next_state;                                // RULE_02
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction path; reset loads on the entry edge, in step with the toggle

    always_ff @(posedge tck) begin
        if (rst_tck || next_state == sbt_pkg::ST_RESET) begin
            ir <= `SBT_OP_IDCODE;                               // RULE_08
        end else if (state == sbt_pkg::ST_UPD_IR) begin
            ir <= ir_shift;                                     // RULE_15
        end
    end

    always_ff @(posedge tck) begin
        if (state == sbt_pkg::ST_CAP_IR) begin
            ir_shift <= `SBT_IR_CAPTURE;                        // RULE_09
        end else if (state == sbt_pkg::ST_SHIFT_IR) begin
            ir_shift <= {tdi, ir_shift[`SBT_IR_W-1:1]};         // RULE_15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bypass and identification registers

    always_ff @(posedge tck) begin
        if (state == sbt_pkg::ST_CAP_DR && sel_bypass) begin
            bypass <= 1'b0;                                     // RULE_10
        end else if (state == sbt_pkg::ST_SHIFT_DR && sel_bypass) begin
            bypass <= tdi;                                      // RULE_11
        end
    end

    always_ff @(posedge tck) begin
        if (state == sbt_pkg::ST_CAP_DR && sel_id) begin
            id_shift <= id_value;                               // RULE_13
        end else if (state == sbt_pkg::ST_SHIFT_DR && sel_id) begin
            id_shift <= {tdi, id_shift[`SBT_ID_W-1:1]};         // RULE_13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // boundary register: capture ring, shift, latch preload

    always_ff @(posedge tck) begin                              // RULE_12
        if (state == sbt_pkg::ST_CAP_DR && sel_bsr) begin
            bsr_shift <= ring_q;                                // RULE_18
        end else if (state == sbt_pkg::ST_SHIFT_DR && sel_bsr) begin
            bsr_shift <= {tdi, bsr_shift[`SBT_BSR_MSB:1]};      // RULE_19
        end
    end

    always_ff @(posedge tck) begin
        if (rst_tck || next_state == sbt_pkg::ST_RESET) begin
            bsr_update <= `SBT_BSR_RESET;                       // RULE_21
        end else if (state == sbt_pkg::ST_UPD_DR && sel_bsr) begin
            bsr_update <= bsr_shift;                            // RULE_20
        end
    end

    // one toggle per change of instruction or preload; data is held stable
    always_ff @(posedge tck) begin
        if (rst_tck) begin
            upd_toggle <= 1'b0;
        end else if (upd_event) begin
            upd_toggle <= ~upd_toggle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial output on the falling edge, half a cycle ahead of the sampler

    always_ff @(negedge tck) begin
        if (rst_tck) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;                                     // RULE_06
        end else begin
            tdo    <= next_tdo;                                 // RULE_01
            tdo_oe <= in_shift;                                 // RULE_04
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system side: take a fresh snapshot when the toggle settles

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tog_meta <= 1'b0;
            tog_s2   <= 1'b0;
            tog_s3   <= 1'b0;
        end else if (ce) begin
            tog_meta <= upd_toggle;
            tog_s2   <= tog_meta;
            tog_s3   <= tog_s2;
        end
    end

    // tap reset never touches memory traffic; only these pin controls move
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tog_seen     <= 1'b0;
            ring_out     <= `SBT_BSR_RESET;
            ring_extest  <= 1'b0;
            sys_samplez  <= 1'b0;
            bus_drive_en <= 1'b1;
        end else if (ce && tog_new) begin
            tog_seen     <= tog_s3;
            ring_out     <= bsr_update;                         // RULE_16
            ring_extest  <= (ir == `SBT_OP_EXTEST);             // RULE_22
            sys_samplez  <= (ir == `SBT_OP_SAMPLEZ);
            bus_drive_en <= (ir == `SBT_OP_SAMPLEZ) ? 1'b0 :    // RULE_17
                            (ir == `SBT_OP_EXTEST)  ? bsr_update[`SBT_OBT_CELL]
                                                    : 1'b1;     // RULE_20
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_TLR_FIVE: assert property (@(posedge tck) disable iff (rst_tck) // RULE_05
        tms [*5] |=> state == sbt_pkg::ST_RESET)
        else $error("five tms-high edges did not reach reset");

    AST_IR_RESET: assert property (@(posedge tck) disable iff (rst_tck) // RULE_08
        state == sbt_pkg::ST_RESET |=> ir == `SBT_OP_IDCODE)
        else $error("instruction not idcode after reset state");

    AST_CAP_IR: assert property (@(posedge tck) disable iff (rst_tck) // RULE_09
        state == sbt_pkg::ST_CAP_IR |=> ir_shift[1:0] == 2'b01)
        else $error("capture-ir pattern wrong");

    AST_IR_HOLD: assert property (@(posedge tck) disable iff (rst_tck) // RULE_15
        (state != sbt_pkg::ST_UPD_IR) && (state != sbt_pkg::ST_RESET)
        && (next_state != sbt_pkg::ST_RESET) |=> ir == $past(ir))
        else $error("instruction changed outside update-ir");

    AST_BYP_CAP: assert property (@(posedge tck) disable iff (rst_tck) // RULE_10
        (state == sbt_pkg::ST_CAP_DR) && sel_bypass |=> !bypass)
        else $error("bypass flop not cleared on capture");

    AST_ID_CAP: assert property (@(posedge tck) disable iff (rst_tck) // RULE_13
        (state == sbt_pkg::ST_CAP_DR) && sel_id |=> id_shift == id_value)
        else $error("id register did not load the code");

    AST_BSR_SHIFT: assert property (@(posedge tck) disable iff (rst_tck) // RULE_03
        (state == sbt_pkg::ST_SHIFT_DR) && sel_bsr
        |=> bsr_shift[`SBT_BSR_MSB] == $past(tdi)
            && bsr_shift[`SBT_BSR_MSB-1:0] == $past(bsr_shift[`SBT_BSR_MSB:1]))
        else $error("boundary shift not msb-in lsb-out");

    AST_BSR_UPD: assert property (@(posedge tck) disable iff (rst_tck) // RULE_19
        (state == sbt_pkg::ST_UPD_DR) && sel_bsr |=> bsr_update == $past(bsr_shift))
        else $error("preload not latched at update-dr");

    AST_CELL_PRESET: assert property (@(posedge tck) disable iff (rst_tck) // RULE_21
        state == sbt_pkg::ST_RESET |=> bsr_update[`SBT_OBT_CELL])
        else $error("tri-state cell not preset high");

    AST_TDO_OE: assert property (@(posedge tck) disable iff (rst_tck) // RULE_04
        (in_shift || tdo_oe) |-> tdo_oe == in_shift)
        else $error("tdo enable outside shift states");

    AST_BUS_OFF: assert property (@(posedge clk_sys) disable iff (rst) // RULE_17
        !bus_drive_en |-> sys_samplez || (ring_extest && !ring_out[`SBT_OBT_CELL]))
        else $error("output bus off without cause");

    COV_UPD_IR: cover property (@(posedge tck) disable iff (rst_tck)
        state == sbt_pkg::ST_UPD_IR);

    COV_ID_SHIFT: cover property (@(posedge tck) disable iff (rst_tck)
        (state == sbt_pkg::ST_SHIFT_DR) && sel_id);

    COV_EXTEST_SHIFT: cover property (@(posedge tck) disable iff (rst_tck)
        (state == sbt_pkg::ST_SHIFT_DR) && (ir == `SBT_OP_EXTEST));

    COV_BUS_OFF: cover property (@(posedge clk_sys) disable iff (rst)
        ring_extest && !bus_drive_en);

endmodule : sbt_tap

`default_nettype wire

// ---- tb/sbt_host_model.sv ----
// Purpose : test-controller side of the link: gated link clock, resolved tdo line
// Assumes : the link clock parks low between frames
// Notes   : a released tdo shows the inverse of its last value, never a stale copy
`default_nettype none

module sbt_host_model (
    // frame control
    input  wire logic tck_run,
    // link
    output logic      tck,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output logic      tdo_line
);
    timeunit 1ns;
    timeprecision 100ps;

    logic last = 1'b0;

    initial tck = 1'b0;

    // 15 ns link clock, finishes its high phase before it stops
    always begin
        #7.5;
        if (tck_run || tck) tck = ~tck;
    end

    // remember the last driven bit so a released line cannot pass for data
    always @(tdo or tdo_oe) begin
        if (tdo_oe) last = tdo;
    end

    assign tdo_line = tdo_oe ? tdo : ~last;

endmodule : sbt_host_model

`default_nettype wire

// ---- tb/tb.sv ----
// Purpose : self-checking bench of the boundary-scan tap
// Assumes : bench acts as the test controller, tms idles high like a pull-up
// Notes   : ring outputs are checked after a fixed clk_sys settling span
`include "sbt_defines.svh"
`default_nettype none
`define SBT_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] ID_EXP = {`SBT_ID_REV, `SBT_ID_PART, `SBT_ID_MFR, 1'h1};
    localparam logic [88:0] P1 = 89'h1A5_5A5A_F00F_1234_ABCD_8765;
    localparam logic [88:0] P2 = 89'h0C3_3CC3_0FF0_9876_5432_1FED;

    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        ce      = 1'b1;
    logic        tck_run = 1'b1;
    logic        tms     = 1'b1;
    logic        tdi     = 1'b1;
    logic        tck;
    logic        tdo;
    logic        tdo_oe;
    logic        tdo_line;
    logic [88:0] ring_in = '0;
    logic [88:0] ring_out;
    logic        ring_extest;
    logic        bus_drive_en;
    logic [88:0] o;
    int          fail_count = 0;
    int          tests_run  = 0;

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    sbt_tap sbt_tap_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
        .ring_extest(ring_extest), .bus_drive_en(bus_drive_en));

    sbt_host_model sbt_host_model_i (.tck_run(tck_run), .tck(tck), .tdo(tdo),
        .tdo_oe(tdo_oe), .tdo_line(tdo_line));

    ////////////////////////////////////////////////////////////////////////////////
    // one link cycle, called just after a rise: set tms/tdi, read tdo the rise takes
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        @(posedge tck);
        q = tdo_line;
    endtask : step

    // walk the controller with a tms sequence, lsb first
    task automatic go(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++) step(seq[i], 1'b0, q);
    endtask : go

    // shift n bits lsb first, leaving through exit1 on the last bit
    task automatic shift(input int n, input logic [88:0] din, output logic [88:0] dout);
        logic q;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
            if (i == 0) `SBT_CHK(tdo_oe, 1'b1)
        end
    endtask : shift

    // idle -> shift-ir -> update-ir -> idle
    task automatic load_ir(input logic [2:0] op);
        go(8'b0000_0011, 4);
        shift(3, {86'h0, op}, o);
        `SBT_CHK(o[2:0], 3'h1)
        go(8'b0000_0001, 2);
    endtask : load_ir

    // idle -> capture-dr -> shift-dr -> update-dr -> idle
    task automatic scan_dr(input int n, input logic [88:0] din);
        go(8'b0000_0001, 3);
        shift(n, din, o);
        go(8'b0000_0001, 2);
    endtask : scan_dr

    // let ring updates cross; end on a link rise so the next step starts cleanly
    task automatic settle();
        repeat (8) @(posedge clk_sys);
        @(posedge tck);
    endtask : settle

    // close a frame: link clock stands still for a moment
    task automatic done(input string name);
        tck_run <= 1'b0;
        repeat (10) @(posedge clk_sys);
        tck_run <= 1'b1;
        @(posedge tck);
        $display("test %s finished, mismatches so far %0d", name, fail_count);
    endtask : done

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `SBT_CHK(tdo_oe, 1'b0)
        `SBT_CHK(ring_out[88], 1'b1)
        scan_dr(32, 89'h0);
        `SBT_CHK(o[31:0], ID_EXP)
        `SBT_CHK(tdo_oe, 1'b0)
        done("reset_idcode");
    endtask : t_reset

    task automatic t_bypass();
        load_ir(`SBT_OP_BYPASS);
        scan_dr(4, 89'hB);
        `SBT_CHK(o[3:0], 4'h6)
        done("bypass");
    endtask : t_bypass

    task automatic t_sample();
        ring_in <= P1;
        load_ir(`SBT_OP_SAMPLE);
        settle();
        ce <= 1'b0;
        scan_dr(89, P2);
        `SBT_CHK(o, P1)
        settle();
        `SBT_CHK(ring_out, `SBT_BSR_RESET)
        ce <= 1'b1;
        settle();
        `SBT_CHK(ring_out, P2)
        `SBT_CHK({ring_extest, bus_drive_en}, 2'b01)
        done("sample_preload");
    endtask : t_sample

    task automatic t_extest();
        load_ir(`SBT_OP_EXTEST);
        settle();
        `SBT_CHK({ring_extest, bus_drive_en}, 2'b10)
        scan_dr(89, {1'b1, P2[87:0]});
        `SBT_CHK(o, P1)
        settle();
        `SBT_CHK({ring_out[88], bus_drive_en}, 2'b11)
        done("extest");
    endtask : t_extest

    task automatic t_samplez();
        load_ir(`SBT_OP_SAMPLEZ);
        scan_dr(89, P2);
        `SBT_CHK(o, P1)
        settle();
        `SBT_CHK({ring_extest, bus_drive_en, ring_out[88]}, 3'b000)
        go(8'b0000_0001, 3);
        go(8'b0001_1111, 6);
        settle();
        `SBT_CHK({ring_out[88], bus_drive_en, tdo_oe}, 3'b110)
        scan_dr(32, 89'h0);
        `SBT_CHK(o[31:0], ID_EXP)
        done("samplez_tlr");
    endtask : t_samplez

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // watchdog, several times the expected run
    initial begin
        #100us;
        fail_count++;
        finish_test();
    end

    // main sequence; reset spans enough link cycles to reach the tap
    initial begin
        repeat (6) @(posedge tck);
        @(posedge clk_sys) rst <= 1'b0;
        repeat (8) @(posedge tck);
        go(8'h00, 1);
        t_reset();
        t_bypass();
        t_sample();
        t_extest();
        t_samplez();
        finish_test();
    end

endmodule : tb

`default_nettype wire
